// >>> verilog/rbe_map.vh
`ifndef RBE_MAP_VH
`define RBE_MAP_VH
// clock and bit rates
`define RBE_CLK_HZ 40000000
`define RBE_BAUD_0 2400
`define RBE_BAUD_1 9600
`define RBE_BAUD_2 19200
`define RBE_BAUD_3 28800
// packet layout, lsb first
`define RBE_ADDR_W 24
`define RBE_DATA_W 8
`define RBE_PKT_W 34
`define RBE_START_POS 0
`define RBE_ADDR_POS 1
`define RBE_DATA_POS 25
`define RBE_STOP_POS 33
// reset value of the stored identity
`define RBE_ADDR_RST 24'h5A3C96
// lfsr taps for the address generator
`define RBE_LFSR_TAPS 24'hE10000
`endif

// >>> verilog/rbe_fifo.v
`timescale 1ns/1ps
`default_nettype none
module rbe_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_q] <= in_data_i;
    if (sys_rst_i)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // rbe_fifo
`default_nettype wire

// >>> verilog/rbe_encoder.v
`timescale 1ns/1ps
`include "rbe_map.vh"
`default_nettype none
module rbe_encoder #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [`RBE_DATA_W-1:0] button_inputs_i,
  input wire send_request_i,
  input wire new_id_request_i,
  input wire baud_select_low_i,
  input wire baud_select_high_i,
  output reg serial_tx_line_o,
  output reg transmitter_power_ctl_o,
  output reg address_mode_lamp_o
);
  localparam integer DIV0_I = `RBE_CLK_HZ / `RBE_BAUD_0;
  localparam integer DIV1_I = `RBE_CLK_HZ / `RBE_BAUD_1;
  localparam integer DIV2_I = `RBE_CLK_HZ / `RBE_BAUD_2;
  localparam integer DIV3_I = `RBE_CLK_HZ / `RBE_BAUD_3;
  localparam integer PKT_LAST_I = `RBE_PKT_W - 1;
  localparam [15:0] DIV0 = DIV0_I[15:0];
  localparam [15:0] DIV1 = DIV1_I[15:0];
  localparam [15:0] DIV2 = DIV2_I[15:0];
  localparam [15:0] DIV3 = DIV3_I[15:0];
  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_SEND = 2'h2;
  localparam [1:0] ST_DRAIN = 2'h3;
  localparam [5:0] PKT_LAST = PKT_LAST_I[5:0];

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers, every button and control pin passes two flops
  reg [`RBE_DATA_W-1:0] btn_m_q;
  reg [`RBE_DATA_W-1:0] btn_s_q;
  reg [3:0] ctl_m_q;
  reg [3:0] ctl_s_q;
  reg send_d1_q;
  reg newid_d1_q;
  wire send_s;
  wire newid_s;
  always @(posedge clk_i)
  begin
    btn_m_q <= button_inputs_i;
    btn_s_q <= btn_m_q;
    ctl_m_q <= {baud_select_high_i, baud_select_low_i, new_id_request_i,
                send_request_i};
    ctl_s_q <= ctl_m_q;
  end
  assign send_s = ctl_s_q[0];
  assign newid_s = ctl_s_q[1];

  //////////////////////////////////////////////////////////////////////////
  // rate latch and bit enable
  function [15:0] rbe_div;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: rbe_div = DIV0;
        2'h1: rbe_div = DIV1;
        2'h2: rbe_div = DIV2;
        default: rbe_div = DIV3;
      endcase
    end
  endfunction

  reg [1:0] state_q;
  reg [1:0] boot_q;
  reg [15:0] div_q;
  reg [15:0] bcnt_q;
  reg bit_en_q;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      boot_q <= 2'h0;
      div_q <= 16'h0000;
      bcnt_q <= 16'h0000;
      bit_en_q <= 1'b0;
    end
    else
    begin
      // wait for synchroniser to fill, then latch once
      if (boot_q != 2'h3)
        boot_q <= boot_q + 2'h1;
      if (boot_q == 2'h2)
        div_q <= rbe_div(ctl_s_q[3:2]);
      bit_en_q <= 1'b0;
      if (state_q == ST_BOOT || bcnt_q == 16'h0000)
        bcnt_q <= div_q - 16'h0001;
      else
        bcnt_q <= bcnt_q - 16'h0001;
      if (state_q != ST_BOOT && bcnt_q == 16'h0000)
        bit_en_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address creation
  reg [`RBE_ADDR_W-1:0] lfsr_q;
  reg [`RBE_ADDR_W-1:0] addr_q;
  always @(posedge clk_i)
  begin
    newid_d1_q <= newid_s;
    if (sys_rst_i)
    begin
      lfsr_q <= `RBE_ADDR_RST;
      addr_q <= `RBE_ADDR_RST;
      address_mode_lamp_o <= 1'b0;
      newid_d1_q <= 1'b0;
    end
    else
    begin
      // free running so the seed depends on press timing
      lfsr_q <= {lfsr_q[`RBE_ADDR_W-2:0],
                 ^(lfsr_q & `RBE_LFSR_TAPS)};
      address_mode_lamp_o <= newid_s;
      if (newid_d1_q & ~newid_s)
        addr_q <= lfsr_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // packet build into fifo, send state machine
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`RBE_PKT_W-1:0] fifo_out_data;
  reg build_q;
  reg pop_q;
  reg [`RBE_PKT_W-1:0] pkt_q;
  reg busy_q;
  reg [5:0] bit_q;
  wire [`RBE_PKT_W-1:0] pkt_new;
  assign pkt_new = {1'b1, btn_s_q, addr_q, 1'b0};

  rbe_fifo #(
    .WIDTH(`RBE_PKT_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(build_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pkt_new),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop_q),
    .out_data_o(fifo_out_data)
  );

  always @(posedge clk_i)
  begin
    send_d1_q <= send_s;
    if (sys_rst_i)
    begin
      state_q <= ST_BOOT;
      build_q <= 1'b0;
      pop_q <= 1'b0;
      busy_q <= 1'b0;
      bit_q <= 6'h00;
      pkt_q <= {`RBE_PKT_W{1'b1}};
      serial_tx_line_o <= 1'b1;
      transmitter_power_ctl_o <= 1'b0;
      send_d1_q <= 1'b0;
    end
    else
    begin
      pop_q <= 1'b0;
      // one packet queued per frame while send holds; fifo stalls builds
      build_q <= 1'b0;
      if (send_s && state_q == ST_SEND && !busy_q && !build_q &&
          !fifo_out_valid && fifo_in_ready)
        build_q <= 1'b1;
      if (bit_en_q)
      begin
        if (busy_q)
        begin
          serial_tx_line_o <= pkt_q[bit_q];
          if (bit_q == PKT_LAST)
            busy_q <= 1'b0;
          else
            bit_q <= bit_q + 6'h01;
        end
        else
        begin
          serial_tx_line_o <= 1'b1;
          if (fifo_out_valid)
          begin
            pkt_q <= fifo_out_data;
            pop_q <= 1'b1;
            busy_q <= 1'b1;
            bit_q <= 6'h00;
          end
        end
      end
      case (state_q)
        ST_BOOT:
          if (boot_q == 2'h3)
            state_q <= send_s ? ST_SEND : ST_SLEEP;
        ST_SLEEP:
        begin
          transmitter_power_ctl_o <= 1'b0;
          if (send_s & ~send_d1_q || send_s)
            state_q <= ST_SEND;
        end
        ST_SEND:
        begin
          transmitter_power_ctl_o <= 1'b1;
          if (!send_s)
            state_q <= ST_DRAIN;
        end
        ST_DRAIN:
          // finish the frame on the line before powering down
          if (!busy_q && !fifo_out_valid && !build_q && !pop_q)
          begin
            transmitter_power_ctl_o <= 1'b0;
            state_q <= ST_SLEEP;
          end
          else if (send_s)
            state_q <= ST_SEND;
        default:
          state_q <= ST_BOOT;
      endcase
    end
  end
endmodule // rbe_encoder
`default_nettype wire

// >>> sim/rbe_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rbe_monitor (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] button_inputs_i,
  input wire logic send_request_i,
  input wire logic new_id_request_i,
  input wire logic baud_select_low_i,
  input wire logic baud_select_high_i,
  input wire logic serial_tx_line_o,
  input wire logic transmitter_power_ctl_o,
  input wire logic address_mode_lamp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rst_idle: assert property ($fell(sys_rst_i) |-> serial_tx_line_o &&
    !transmitter_power_ctl_o && !address_mode_lamp_o) else $error("idle");
  a_lamp_on: assert property (new_id_request_i[*5] |->
    address_mode_lamp_o) else $error("lamp stays low");
  a_lamp_off: assert property ((!new_id_request_i)[*5] |->
    !address_mode_lamp_o) else $error("lamp stays high");
  a_pwr_on: assert property (send_request_i[*5] |->
    transmitter_power_ctl_o) else $error("power stays low");
  a_pwr_cause: assert property ($rose(transmitter_power_ctl_o) |->
    $past(send_request_i)) else $error("power without send");
  a_tx_idle: assert property (!transmitter_power_ctl_o |->
    serial_tx_line_o) else $error("line busy while unpowered");
  a_pwr_end: assert property ($fell(transmitter_power_ctl_o) |->
    !send_request_i && serial_tx_line_o) else $error("power cut early");
  a_bit_low: assert property ($fell(serial_tx_line_o) |=>
    (!serial_tx_line_o)[*8]) else $error("bit too short");
  cover property (address_mode_lamp_o);
  cover property ($fell(serial_tx_line_o));
  cover property ($fell(transmitter_power_ctl_o));
endmodule // rbe_monitor
bind rbe_encoder rbe_monitor i_rbe_monitor (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .button_inputs_i(button_inputs_i),
  .send_request_i(send_request_i), .new_id_request_i(new_id_request_i),
  .baud_select_low_i(baud_select_low_i),
  .baud_select_high_i(baud_select_high_i),
  .serial_tx_line_o(serial_tx_line_o),
  .transmitter_power_ctl_o(transmitter_power_ctl_o),
  .address_mode_lamp_o(address_mode_lamp_o));
`default_nettype wire

// >>> sim/rbe_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module rbe_tx_model #(
  parameter int BIT = 1388
) (
  input wire logic clk_i,
  input wire logic tx_line_i,
  input wire logic power_i,
  output logic [33:0] frame_o,
  output logic got_o
);
  // fixed bit clock: a wrong rate shows up as a garbled frame
  initial
  begin
    got_o = 1'b0;
    frame_o = '0;
    forever
    begin
      @(negedge tx_line_i iff power_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 34; i++)
      begin
        frame_o[i] = tx_line_i;
        if (i < 33) repeat (BIT) @(posedge clk_i);
      end
      got_o = 1'b1;
    end
  end
endmodule // rbe_tx_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] buttons = 8'hA5;
  logic send = 1'b0;
  logic new_id = 1'b0;
  logic bsel_lo = 1'b1;
  logic bsel_hi = 1'b1;
  wire tx, pwr, lamp, got;
  wire [33:0] frame;
  int errors = 0;
  int num_checks = 0;
  int low = 0;
  rbe_encoder i_rbe_encoder (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .button_inputs_i(buttons), .send_request_i(send),
    .new_id_request_i(new_id), .baud_select_low_i(bsel_lo),
    .baud_select_high_i(bsel_hi), .serial_tx_line_o(tx),
    .transmitter_power_ctl_o(pwr), .address_mode_lamp_o(lamp));
  rbe_tx_model i_rbe_tx_model (.clk_i(clk_i), .tx_line_i(tx),
    .power_i(pwr), .frame_o(frame), .got_o(got));
  initial forever #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic create_id(input int n);
    new_id = 1'b1;
    cyc(n);
    check(34'(lamp), 34'h1);
    new_id = 1'b0;
    cyc(6);
    check(34'(lamp), 34'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    check(34'({tx, pwr, lamp}), 34'h4);
    sys_rst_i = 1'b0;
    cyc(6);
    // pins move after boot; the frame must still use the latched rate
    bsel_lo = 1'b0;
    bsel_hi = 1'b0;
    create_id(20);
    send = 1'b1;
    cyc(5);
    check(34'(pwr), 34'h1);
    cyc(10);
    buttons = 8'h3C;
    cyc(5);
    send = 1'b0;
    cyc(100);
    check(34'(pwr), 34'h1);
    for (int i = 0; i < 60000 && got !== 1'b1; i++)
      @(negedge clk_i);
    check(34'(got), 34'h1);
    check(34'({frame[33], frame[0]}), 34'h2);
    check(34'(frame[32:25]), 34'hA5);
    check(34'(frame[24:1] != 24'h5A3C96), 34'h1);
    cyc(3000);
    check(34'({tx, pwr}), 34'h2);
    // second boot at 19200 with send rising just as boot ends
    bsel_hi = 1'b1;
    sys_rst_i = 1'b1;
    cyc(3);
    sys_rst_i = 1'b0;
    cyc(1);
    send = 1'b1;
    for (int i = 0; i < 10000 && tx !== 1'b0; i++)
      @(negedge clk_i);
    for (low = 0; low < 10000 && tx === 1'b0; low++)
      @(negedge clk_i);
    // start bit and bit 0 of the reset identity: two bits of 2083 cycles
    check(34'(low), 34'h1046);
    // reset in mid frame: outputs idle at once and after the new boot
    send = 1'b0;
    sys_rst_i = 1'b1;
    cyc(2);
    check(34'({tx, pwr, lamp}), 34'h4);
    sys_rst_i = 1'b0;
    cyc(10);
    check(34'({tx, pwr, lamp}), 34'h4);
    summarize();
  end
  initial
  begin
    repeat (70000) @(posedge clk_i);
    errors++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
